// >>> inc/brw_pkg.sv
package brw_pkg;

	// ----------------------------------------------------------------
	// Command codes of the report words
	// ----------------------------------------------------------------
	localparam logic [7:0] BRW_CMD_FULL_TANK = 8'h10;
	localparam logic [7:0] BRW_CMD_MIN_NOW = 8'h11;
	localparam logic [7:0] BRW_CMD_MIN_SMOOTH = 8'h12;
	localparam logic [7:0] BRW_CMD_MIN_FULL = 8'h13;
	localparam logic [7:0] BRW_CMD_CHG_CUR = 8'h14;
	localparam logic [7:0] BRW_CMD_CHG_VOLT = 8'h15;
	localparam logic [7:0] BRW_CMD_FLAGS = 8'h16;

	// ----------------------------------------------------------------
	// Status word bit positions and error field
	// ----------------------------------------------------------------
	localparam int BRW_BIT_OVCHG = 15;
	localparam int BRW_BIT_TERM_CHG = 14;
	localparam int BRW_BIT_RSVD_HI = 13;
	localparam int BRW_BIT_OVTEMP = 12;
	localparam int BRW_BIT_TERM_DSG = 11;
	localparam int BRW_BIT_RSVD_LO = 10;
	localparam int BRW_BIT_LOW_CAP = 9;
	localparam int BRW_BIT_LOW_TIME = 8;
	localparam int BRW_BIT_INIT = 7;
	localparam int BRW_BIT_NOT_CHG = 6;
	localparam int BRW_BIT_FULL = 5;
	localparam int BRW_BIT_EMPTY = 4;
	localparam int BRW_ERR_LSB = 0;
	localparam int BRW_ERR_W = 3;

	localparam logic [2:0] BRW_ERR_OK = 3'h0;
	localparam logic [2:0] BRW_ERR_BUSY = 3'h1;
	localparam logic [2:0] BRW_ERR_RSVD_CMD = 3'h2;
	localparam logic [2:0] BRW_ERR_UNSUPPORTED = 3'h3;
	localparam logic [2:0] BRW_ERR_DENIED = 3'h4;
	localparam logic [2:0] BRW_ERR_OVERFLOW = 3'h5;
	localparam logic [2:0] BRW_ERR_BAD_SIZE = 3'h6;
	localparam logic [2:0] BRW_ERR_UNKNOWN = 3'h7;

	// ----------------------------------------------------------------
	// Values after reset and counts
	// ----------------------------------------------------------------
	localparam logic [15:0] BRW_NO_TIME = 16'hffff;
	localparam logic [15:0] BRW_WORD_RST = 16'h0000;
	localparam logic [2:0] BRW_ERR_RST = 3'h0;
	localparam logic [1:0] BRW_OVCHG_CLR_MAH = 2'h2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] full_mah;
		logic [15:0] full_cwh;
		logic [15:0] left_mah;
		logic [15:0] left_cwh;
		logic [15:0] now_min_cur;
		logic [15:0] now_min_pwr;
		logic [15:0] avg_min_cur;
		logic [15:0] avg_min_pwr;
		logic [15:0] full_min;
		logic [15:0] chg_current;
		logic [15:0] chg_voltage;
	} brw_gauge_t;

	typedef struct packed {
		logic charging;
		logic discharging;
		logic primary_term;
		logic over_limit;
		logic idle_mah_tick;
		logic [15:0] temp;
		logic [15:0] ot_chg_set;
		logic [15:0] ot_chg_rst;
		logic [15:0] ot_dsg_set;
		logic [15:0] ot_dsg_rst;
		logic [15:0] voltage;
		logic [15:0] term_voltage;
		logic [15:0] suspend_low;
		logic cell_undervolt_flag;
		logic [7:0] rsoc;
		logic [7:0] full_clear_pct;
		logic flash_ok;
		logic empty_flag;
	} brw_cond_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] cmd;
	} brw_req_t;

endpackage : brw_pkg

// >>> src/brw_report_bank.sv
`timescale 1ns/10ps
module brw_report_bank
	import brw_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic energy_units,
	input wire logic update_tick,
	input wire brw_gauge_t gauge,
	input wire brw_cond_t cond,
	input wire logic [15:0] low_charge_threshold,
	input wire logic [15:0] low_minutes_threshold,
	input wire brw_req_t req,
	output logic resp_valid,
	output logic [15:0] resp_data,
	output logic alert_valid,
	output logic [15:0] alert_broadcast,
	output logic [15:0] status_word
);

	// ----------------------------------------------------------------
	// Report word snapshots, refreshed on the gauge update tick
	// ----------------------------------------------------------------
	logic [15:0] full_ff, nxt_full;
	logic [15:0] now_ff, nxt_now;
	logic [15:0] avg_ff, nxt_avg;
	logic [15:0] tofull_ff, nxt_tofull;
	logic [15:0] icur_ff, nxt_icur;
	logic [15:0] ivolt_ff, nxt_ivolt;
	logic [15:0] left_sel;
	logic [15:0] now_sel;
	logic [15:0] avg_sel;

	always_comb begin
		left_sel = energy_units ? gauge.left_cwh : gauge.left_mah;
		now_sel = energy_units ? gauge.now_min_pwr : gauge.now_min_cur;
		avg_sel = energy_units ? gauge.avg_min_pwr : gauge.avg_min_cur;
		nxt_full = full_ff;
		nxt_now = now_ff;
		nxt_avg = avg_ff;
		nxt_tofull = tofull_ff;
		nxt_icur = icur_ff;
		nxt_ivolt = ivolt_ff;
		if (update_tick) begin
			nxt_full = energy_units ? gauge.full_cwh : gauge.full_mah;
			nxt_now = cond.discharging ? now_sel : BRW_NO_TIME;
			nxt_avg = cond.discharging ? avg_sel : BRW_NO_TIME;
			nxt_tofull = cond.charging ? gauge.full_min : BRW_NO_TIME;
			// Zero stops the charger and all ones asks for a voltage source.
			nxt_icur = gauge.chg_current;
			nxt_ivolt = gauge.chg_voltage;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			full_ff <= BRW_WORD_RST;
			now_ff <= BRW_NO_TIME;
			avg_ff <= BRW_NO_TIME;
			tofull_ff <= BRW_NO_TIME;
			icur_ff <= BRW_WORD_RST;
			ivolt_ff <= BRW_WORD_RST;
		end else begin
			full_ff <= nxt_full;
			now_ff <= nxt_now;
			avg_ff <= nxt_avg;
			tofull_ff <= nxt_tofull;
			icur_ff <= nxt_icur;
			ivolt_ff <= nxt_ivolt;
		end
	end

	// ----------------------------------------------------------------
	// Alarm and status flags
	// ----------------------------------------------------------------
	logic ovchg_ff, tchg_ff, otemp_ff, tdsg_ff, lcap_ff, ltime_ff, full_flag_ff;
	logic [1:0] idle_mah_ff, nxt_idle_mah;
	logic ov_set, ov_clr, tc_set, tc_clr, ot_set, ot_clr, td_set, td_clr;
	logic lc_set, lc_clr, lt_set, lt_clr, ff_set, ff_clr;

	always_comb begin
		nxt_idle_mah = idle_mah_ff;
		if (cond.charging) begin
			nxt_idle_mah = 2'h0;
		end else if (cond.idle_mah_tick && idle_mah_ff != BRW_OVCHG_CLR_MAH) begin
			nxt_idle_mah = idle_mah_ff + 2'h1;
		end
		ov_set = cond.over_limit;
		ov_clr = !cond.charging && idle_mah_ff == BRW_OVCHG_CLR_MAH;
		tc_set = cond.primary_term;
		tc_clr = !cond.charging;
		ot_set = (cond.charging && cond.temp >= cond.ot_chg_set) ||
			(cond.discharging && cond.temp >= cond.ot_dsg_set);
		ot_clr = cond.discharging ? (cond.temp < cond.ot_dsg_rst) :
			(cond.temp < cond.ot_chg_rst);
		td_set = (gauge.left_mah == 16'h0000) || (cond.voltage == cond.term_voltage) ||
			(cond.temp <= cond.suspend_low) || cond.cell_undervolt_flag;
		td_clr = (cond.voltage > cond.term_voltage) && (gauge.left_mah != 16'h0000) &&
			!cond.cell_undervolt_flag;
		// Units follow the mode bit so a mAh threshold never meets a cWh value.
		lc_set = left_sel < low_charge_threshold;
		lc_clr = !lc_set;
		// The run-time minute snapshots now_ff and avg_ff read all ones unless discharging, so charging clears.
		lt_set = now_ff < low_minutes_threshold;
		lt_clr = low_minutes_threshold < avg_ff;
		ff_set = cond.primary_term || cond.over_limit;
		ff_clr = cond.rsoc < cond.full_clear_pct;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			idle_mah_ff <= 2'h0;
		end else begin
			idle_mah_ff <= nxt_idle_mah;
		end
	end

	brw_sr_flag u_ovchg (
		.mclk(mclk),
		.rst_n(rst_n),
		.set_req(ov_set),
		.clr_req(ov_clr),
		.flag(ovchg_ff)
	);

	brw_sr_flag u_tchg (
		.mclk(mclk),
		.rst_n(rst_n),
		.set_req(tc_set),
		.clr_req(tc_clr),
		.flag(tchg_ff)
	);

	brw_sr_flag u_otemp (
		.mclk(mclk),
		.rst_n(rst_n),
		.set_req(ot_set),
		.clr_req(ot_clr),
		.flag(otemp_ff)
	);

	brw_sr_flag u_tdsg (
		.mclk(mclk),
		.rst_n(rst_n),
		.set_req(td_set),
		.clr_req(td_clr),
		.flag(tdsg_ff)
	);

	brw_sr_flag u_lcap (
		.mclk(mclk),
		.rst_n(rst_n),
		.set_req(lc_set),
		.clr_req(lc_clr),
		.flag(lcap_ff)
	);

	brw_sr_flag u_ltime (
		.mclk(mclk),
		.rst_n(rst_n),
		.set_req(lt_set),
		.clr_req(lt_clr),
		.flag(ltime_ff)
	);

	brw_sr_flag u_full (
		.mclk(mclk),
		.rst_n(rst_n),
		.set_req(ff_set),
		.clr_req(ff_clr),
		.flag(full_flag_ff)
	);

	// ----------------------------------------------------------------
	// Command port, error code and alert broadcast
	// ----------------------------------------------------------------
	logic [2:0] err_ff, nxt_err;
	logic [15:0] status_comb;
	logic [7:0] alarms_now, alarms_prev_ff;
	logic hit;
	logic resp_valid_ff, nxt_resp_valid;
	logic [15:0] resp_data_ff, nxt_resp_data;
	logic alert_valid_ff, nxt_alert_valid;
	logic [15:0] alert_ff, nxt_alert;

	always_comb begin
		status_comb = 16'h0000;
		status_comb[BRW_BIT_OVCHG] = ovchg_ff;
		status_comb[BRW_BIT_TERM_CHG] = tchg_ff;
		status_comb[BRW_BIT_RSVD_HI] = 1'b0;
		status_comb[BRW_BIT_OVTEMP] = otemp_ff;
		status_comb[BRW_BIT_TERM_DSG] = tdsg_ff;
		status_comb[BRW_BIT_RSVD_LO] = 1'b0;
		status_comb[BRW_BIT_LOW_CAP] = lcap_ff;
		status_comb[BRW_BIT_LOW_TIME] = ltime_ff;
		status_comb[BRW_BIT_INIT] = cond.flash_ok;
		status_comb[BRW_BIT_NOT_CHG] = !cond.charging;
		status_comb[BRW_BIT_FULL] = full_flag_ff;
		status_comb[BRW_BIT_EMPTY] = cond.empty_flag;
		status_comb[BRW_ERR_LSB +: BRW_ERR_W] = err_ff;
		alarms_now = status_comb[15:8];
		hit = req.cmd >= BRW_CMD_FULL_TANK && req.cmd <= BRW_CMD_FLAGS;
		nxt_err = err_ff;
		nxt_resp_valid = 1'b0;
		nxt_resp_data = resp_data_ff;
		if (req.valid) begin
			nxt_resp_valid = 1'b1;
			if (!hit) begin
				nxt_err = BRW_ERR_UNSUPPORTED;
				nxt_resp_data = 16'h0000;
			end else if (req.write) begin
				// All words here are read-only.
				nxt_err = BRW_ERR_DENIED;
				nxt_resp_data = 16'h0000;
			end else begin
				nxt_err = BRW_ERR_OK;
				case (req.cmd)
					BRW_CMD_FULL_TANK: nxt_resp_data = full_ff;
					BRW_CMD_MIN_NOW: nxt_resp_data = now_ff;
					BRW_CMD_MIN_SMOOTH: nxt_resp_data = avg_ff;
					BRW_CMD_MIN_FULL: nxt_resp_data = tofull_ff;
					BRW_CMD_CHG_CUR: nxt_resp_data = icur_ff;
					BRW_CMD_CHG_VOLT: nxt_resp_data = ivolt_ff;
					BRW_CMD_FLAGS: nxt_resp_data = status_comb;
					default: nxt_resp_data = 16'h0000;
				endcase
			end
		end
		// A broadcast goes out whenever a new alarm rises.
		nxt_alert_valid = |(alarms_now & ~alarms_prev_ff);
		nxt_alert = alert_ff;
		if (nxt_alert_valid) begin
			nxt_alert = {status_comb[15:BRW_ERR_W], BRW_ERR_UNKNOWN};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			err_ff <= BRW_ERR_RST;
			alarms_prev_ff <= 8'h00;
			resp_valid_ff <= 1'b0;
			resp_data_ff <= BRW_WORD_RST;
			alert_valid_ff <= 1'b0;
			alert_ff <= BRW_WORD_RST;
		end else begin
			err_ff <= nxt_err;
			alarms_prev_ff <= alarms_now;
			resp_valid_ff <= nxt_resp_valid;
			resp_data_ff <= nxt_resp_data;
			alert_valid_ff <= nxt_alert_valid;
			alert_ff <= nxt_alert;
		end
	end

	assign resp_valid = resp_valid_ff;
	assign resp_data = resp_data_ff;
	assign alert_valid = alert_valid_ff;
	assign alert_broadcast = alert_ff;
	assign status_word = status_comb;

endmodule : brw_report_bank

// ----------------------------------------------------------------
// Set-dominant alarm flag
// ----------------------------------------------------------------
module brw_sr_flag
	import brw_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic set_req,
	input wire logic clr_req,
	output logic flag
);

	logic flag_ff, nxt_flag;

	// Set wins over clear, so an event in the clearing cycle is never lost.
	always_comb begin
		nxt_flag = flag_ff;
		if (set_req) begin
			nxt_flag = 1'b1;
		end else if (clr_req) begin
			nxt_flag = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	assign flag = flag_ff;

endmodule : brw_sr_flag

// >>> tb/brw_report_bank_checker.sv
`timescale 1ns/10ps
module brw_report_bank_checker
	import brw_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire brw_cond_t cond,
	input wire brw_req_t req,
	input wire logic resp_valid,
	input wire logic [15:0] resp_data,
	input wire logic alert_valid,
	input wire logic [15:0] alert_broadcast,
	input wire logic [15:0] status_word
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_resp_one_later: assert property (req.valid |=> resp_valid)
		else $error("resp_valid missing one cycle after request");
	a_write_denied: assert property (req.valid && req.write &&
		req.cmd >= 8'h10 && req.cmd <= 8'h16 |=>
		resp_data == 16'h0000 && status_word[2:0] == BRW_ERR_DENIED)
		else $error("write to report word not denied");
	a_unknown_cmd: assert property (req.valid && !req.write &&
		(req.cmd < 8'h10 || req.cmd > 8'h16) |=> status_word[2:0] == BRW_ERR_UNSUPPORTED)
		else $error("unknown command not flagged unsupported");
	a_rsvd_zero: assert property (!status_word[13] && !status_word[10])
		else $error("reserved status bit set");
	a_flag_bits: assert property (status_word[7] == cond.flash_ok &&
		status_word[6] == !cond.charging && status_word[4] == cond.empty_flag)
		else $error("status flag bits do not follow conditions");
	a_alert_ones: assert property (alert_valid |-> alert_broadcast[2:0] == 3'h7)
		else $error("alert error field not all ones");
	a_alert_on_rise: assert property
		((status_word[15:8] & ~$past(status_word[15:8])) != 8'h00 |=> alert_valid)
		else $error("alarm rise without alert");
	a_term_clears: assert property (!cond.charging && !cond.primary_term |=>
		!status_word[14]) else $error("charge-terminate alarm held while not charging");
	a_full_on_term: assert property (cond.primary_term |=> status_word[5])
		else $error("full flag not set on termination");
endmodule : brw_report_bank_checker

bind brw_report_bank brw_report_bank_checker u_chk (.mclk(mclk), .rst_n(rst_n), .cond(cond),
	.req(req), .resp_valid(resp_valid), .resp_data(resp_data), .alert_valid(alert_valid),
	.alert_broadcast(alert_broadcast), .status_word(status_word));

// >>> tb/brw_host_model.sv
`timescale 1ns/10ps
module brw_host_model
	import brw_pkg::*;
(
	input wire logic mclk,
	input wire logic resp_valid,
	input wire logic [15:0] resp_data,
	output brw_req_t req
);
	initial req = '{1'b0, 1'b1, 8'hff};
	task automatic xfer(input logic w, input logic [7:0] c, output logic [15:0] d);
		int n;
		n = 0;
		@(negedge mclk);
		req = '{1'b1, w, c};
		@(negedge mclk);
		// Released fields show the inverse so a stale command cannot look valid.
		req = '{1'b0, ~w, ~c};
		while (resp_valid !== 1'b1 && n < 4) begin
			@(negedge mclk);
			n++;
		end
		d = (n < 4) ? resp_data : 16'hxxxx;
	endtask : xfer
	// The charger takes both request words as one operating point.
	task automatic chg_point(output logic [15:0] i, output logic [15:0] v);
		xfer(1'b0, BRW_CMD_CHG_CUR, i);
		xfer(1'b0, BRW_CMD_CHG_VOLT, v);
	endtask : chg_point
endmodule : brw_host_model

// >>> tb/test_battery_report_and_alarm_words.sv
`timescale 1ns/10ps
module test_battery_report_and_alarm_words
	import brw_pkg::*;
;
	logic mclk, rst_n, energy_units, update_tick, resp_valid, alert_valid;
	brw_gauge_t gauge;
	brw_cond_t cond;
	brw_req_t req;
	logic [15:0] lct, lmt, resp_data, alert_broadcast, status_word, d, ci, cv, bc;
	int n_fail, n_compared, cyc, n_alert;
	brw_report_bank u_dut (.mclk(mclk), .rst_n(rst_n), .energy_units(energy_units),
		.update_tick(update_tick), .gauge(gauge), .cond(cond), .low_charge_threshold(lct),
		.low_minutes_threshold(lmt), .req(req), .resp_valid(resp_valid), .resp_data(resp_data),
		.alert_valid(alert_valid), .alert_broadcast(alert_broadcast), .status_word(status_word));
	brw_host_model u_host (.mclk(mclk), .resp_valid(resp_valid), .resp_data(resp_data),
		.req(req));
	always #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (alert_valid === 1'b1) begin
			n_alert++;
			bc = alert_broadcast;
		end
		if (cyc == 3000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tick();
		@(negedge mclk) update_tick = 1'b1;
		@(negedge mclk) update_tick = 1'b0;
		@(negedge mclk);
	endtask : tick
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		u_host.xfer(1'b0, c, d);
		chk("resp_data", e, d);
	endtask : rd
	// Ticking first lets the alarms see fresh snapshots as well as live inputs.
	task automatic sb(input int b, input logic e);
		tick();
		chk("status bit", {15'h0000, e}, {15'h0000, status_word[b]});
	endtask : sb
	task automatic end_of_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		{mclk, rst_n, energy_units, update_tick, n_fail, n_compared, cyc, n_alert} = '0;
		gauge = '{16'h1234, 16'h0567, 16'h01f4, 16'h01f4, 16'h012c, 16'h012d, 16'h0136,
			16'h0137, 16'h0050, 16'h0bb8, 16'h4268};
		cond = '0;
		cond.discharging = 1'b1;
		cond.temp = 16'h0064;
		{cond.ot_chg_set, cond.ot_dsg_set} = {2{16'h03e8}};
		{cond.ot_chg_rst, cond.ot_dsg_rst} = {2{16'h0384}};
		{cond.voltage, cond.term_voltage} = {16'h0fa0, 16'h0bb8};
		{cond.rsoc, cond.full_clear_pct, cond.flash_ok} = {8'h32, 8'h0a, 1'b1};
		{lct, lmt} = {16'h0064, 16'h0064};
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		chk("alert_broadcast", 16'h0000, alert_broadcast);
		for (int k = 0; k < 2; k++) begin
			energy_units = k[0];
			tick();
			rd(BRW_CMD_FULL_TANK, k ? gauge.full_cwh : gauge.full_mah);
			rd(BRW_CMD_MIN_NOW, k ? gauge.now_min_pwr : gauge.now_min_cur);
			rd(BRW_CMD_MIN_SMOOTH, k ? gauge.avg_min_pwr : gauge.avg_min_cur);
			rd(BRW_CMD_MIN_FULL, BRW_NO_TIME);
		end
		{cond.charging, cond.discharging} = 2'b10;
		tick();
		rd(BRW_CMD_MIN_NOW, BRW_NO_TIME);
		rd(BRW_CMD_MIN_SMOOTH, BRW_NO_TIME);
		rd(BRW_CMD_MIN_FULL, gauge.full_min);
		rd(BRW_CMD_FLAGS, 16'h0080);
		for (int k = 0; k < 2; k++) begin
			gauge.chg_current = {16{k[0]}};
			gauge.chg_voltage = ~gauge.chg_current;
			tick();
			u_host.chg_point(ci, cv);
			chk("charge current", gauge.chg_current, ci);
			chk("charge voltage", gauge.chg_voltage, cv);
		end
		u_host.xfer(1'b1, BRW_CMD_FULL_TANK, d);
		chk("resp_data", 16'h0000, d);
		chk("error", {13'h0000, BRW_ERR_DENIED}, {13'h0000, status_word[2:0]});
		u_host.xfer(1'b0, 8'h17, d);
		chk("error", {13'h0000, BRW_ERR_UNSUPPORTED}, {13'h0000, status_word[2:0]});
		rd(BRW_CMD_FULL_TANK, gauge.full_cwh);
		chk("error", {13'h0000, BRW_ERR_OK}, {13'h0000, status_word[2:0]});
		cond.primary_term = 1'b1;
		sb(14, 1'b1);
		sb(5, 1'b1);
		{cond.primary_term, cond.charging, cond.discharging} = 3'b001;
		sb(14, 1'b0);
		chk("alert count", 16'h0001, n_alert[15:0]);
		chk("alert word", 16'h4027, bc & 16'h4027);
		cond.rsoc = 8'h05;
		sb(5, 1'b0);
		{cond.rsoc, cond.charging, cond.discharging, cond.over_limit} = {8'h32, 3'b101};
		sb(15, 1'b1);
		{cond.charging, cond.discharging, cond.over_limit} = 3'b010;
		for (int j = 0; j < 2; j++) begin
			@(negedge mclk) cond.idle_mah_tick = 1'b1;
			@(negedge mclk) cond.idle_mah_tick = 1'b0;
			sb(15, j == 0);
		end
		cond.temp = 16'h03e8;
		sb(12, 1'b1);
		cond.temp = 16'h0385;
		sb(12, 1'b1);
		cond.temp = 16'h0383;
		sb(12, 1'b0);
		cond.cell_undervolt_flag = 1'b1;
		sb(11, 1'b1);
		{cond.cell_undervolt_flag, cond.voltage} = {1'b0, 16'h0bb8};
		sb(11, 1'b1);
		cond.voltage = 16'h0fa0;
		sb(11, 1'b0);
		lct = 16'h01f5;
		sb(9, 1'b1);
		lct = 16'h01f4;
		sb(9, 1'b0);
		{lct, gauge.left_cwh, energy_units} = {16'h00c8, 16'h0064, 1'b0};
		sb(9, 1'b0);
		energy_units = 1'b1;
		sb(9, 1'b1);
		{lct, energy_units, lmt} = {16'h0064, 1'b0, 16'h012d};
		sb(8, 1'b1);
		energy_units = 1'b1;
		sb(8, 1'b0);
		end_of_test();
	end
endmodule : test_battery_report_and_alarm_words
